// ---- src/gtimer_pkg.sv ----
package gtimer_pkg;

    // ==========================================================
    // Register map (byte address per register, registers one word apart except the unused word at 0x2c)
    // ==========================================================
    localparam logic [7:0] ADDR_CTRL     = 8'h00; // Run, reset, counter mode
    localparam logic [7:0] ADDR_COUNT    = 8'h04; // Main counter value
    localparam logic [7:0] ADDR_PRESCALE = 8'h08; // Prescale reload value
    localparam logic [7:0] ADDR_PCOUNT   = 8'h0c; // Prescale counter value
    localparam logic [7:0] ADDR_MCTRL    = 8'h10; // Match actions
    localparam logic [7:0] ADDR_CCTRL    = 8'h14; // Capture edges, irq enables
    localparam logic [7:0] ADDR_EMCTRL   = 8'h18; // Match output actions, levels
    localparam logic [7:0] ADDR_PWMCTRL  = 8'h1c; // PWM enables
    localparam logic [7:0] ADDR_DMACTRL  = 8'h20; // DMA request source select
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h24; // Sticky events, write one clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h28; // Interrupt mask
    localparam logic [7:0] ADDR_MATCH0   = 8'h30; // Match 0..3 at 0x30..0x3c
    localparam logic [7:0] ADDR_CAP0     = 8'h40; // Capture 0..3 at 0x40..0x4c

    // ==========================================================
    // Sizes and field positions
    // ==========================================================
    localparam int NUM_CH = 4;       // Match and capture channels
    localparam int CTRL_RUN = 0;     // Counting enabled
    localparam int CTRL_RST = 1;     // Hold counter and prescaler at zero
    localparam int CTRL_EXTCLK = 2;  // Count external clock rising edges
    localparam int CTRL_CLRCAP_EN = 3; // Clear on capture event enabled
    localparam int CTRL_CLRCAP_SEL = 4; // Two-bit capture index, bits 5:4
    localparam int IRQ_CAP_BASE = 4; // Capture status bits 7:4

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
    localparam logic [31:0] RST_MATCH = 32'hffff_ffff;

    // Match output actions
    typedef enum logic [1:0] {
        EM_NONE   = 2'h0,
        EM_LOW    = 2'h1,
        EM_HIGH   = 2'h2,
        EM_TOGGLE = 2'h3
    } em_act_t;

    // Capture edge selections
    typedef enum logic [1:0] {
        CAP_OFF  = 2'h0,
        CAP_RISE = 2'h1,
        CAP_FALL = 2'h2,
        CAP_BOTH = 2'h3
    } cap_edge_t;

endpackage : gtimer_pkg

// ---- src/gtimer_capture.sv ----
`timescale 1ns/1ps

// Synchronises one capture pin and flags the selected edges
module gtimer_capture
(
    // Clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_srst,
    // Pin and edge selection
    input  wire logic                      i_pin,
    input  wire gtimer_pkg::cap_edge_t     i_edge,
    // One-cycle capture pulse
    output logic                           o_event
);
    logic sync1_q; // First stage, read only by sync2_q
    logic sync2_q; // Second stage
    logic prev_q;  // Previous synchronised level

    // ==========================================================
    // Two-stage synchroniser and edge history
    // ==========================================================
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // Edge decode per selection
    always_comb
    begin
        case (i_edge)
            gtimer_pkg::CAP_RISE: o_event = sync2_q & ~prev_q;
            gtimer_pkg::CAP_FALL: o_event = ~sync2_q & prev_q;
            gtimer_pkg::CAP_BOTH: o_event = sync2_q ^ prev_q;
            default:              o_event = 1'b0;
        endcase
    end

endmodule : gtimer_capture

// ---- src/gtimer_ext_clk.sv ----
`timescale 1ns/1ps

// Turns the external count clock into one-cycle tick pulses
module gtimer_ext_clk
(
    // Clock and reset
    input  wire logic  i_clk,
    input  wire logic  i_srst,
    // External clock pin
    input  wire logic  i_pin,
    // One pulse per rising edge
    output logic       o_tick
);
    logic sync1_q; // First stage, read only by sync2_q
    logic sync2_q; // Second stage
    logic prev_q;  // Previous level

    // ==========================================================
    // Synchroniser; external rate must stay below half of i_clk
    // ==========================================================
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end
        else
        begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign o_tick = sync2_q & ~prev_q;

endmodule : gtimer_ext_clk

// ---- src/gtimer_top.sv ----
`timescale 1ns/1ps

// Overview of operation
// - 32-bit counter advanced by 32-bit prescaler
// - Count system clock or external clock
// - Four capture registers snapshot counter on edges
// - Per-capture optional interrupt on capture load
// - Four match registers compared with counter continuously
// - Match continues, stops or resets, optional interrupt
// - Shadowed match values for glitch-free PWM
// - Four match outputs: low, high, toggle, none
// - At most two matches issue DMA requests
// - Selected capture clears counter and prescaler
// - Up to three PWM outputs, match3 period
module gtimer_top
(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_srst,
    // Register port
    input  wire logic [7:0]          i_addr,
    input  wire logic [31:0]         i_wdata,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    output logic      [31:0]         o_rdata,
    // External pins
    input  wire logic                i_ext_clk,
    input  wire logic [3:0]          i_cap,
    output logic      [3:0]          o_match,
    // Requests
    output logic      [1:0]          o_dma_req,
    output logic                     o_irq
);
    localparam int NUM_CH = gtimer_pkg::NUM_CH;

    // ==========================================================
    // Registers
    // ==========================================================
    logic [31:0] ctrl_q;               // Control bits
    logic [31:0] count_q;              // Main counter
    logic [31:0] prescale_q;           // Prescale reload value
    logic [31:0] pcount_q;             // Prescale counter
    logic [11:0] mctrl_q;              // Per match: irq, reset, stop
    logic [11:0] cctrl_q;              // Per capture: irq en, edge[1:0]
    logic [11:0] emctrl_q;             // Per output: action[1:0]; levels separate
    logic [3:0]  pwm_en_q;             // PWM mode per output
    logic [3:0]  dmasel_q;             // Two 2-bit match selects
    logic [7:0]  irq_stat_q;           // Match 3:0, capture 7:4
    logic [7:0]  irq_mask_q;           // Interrupt enables
    logic [31:0] match_q [NUM_CH];     // Software match values
    logic [31:0] shadow_q [NUM_CH];    // Active compare values
    logic [31:0] cap_q [NUM_CH];       // Captured counts
    logic [3:0]  match_out_q;          // External match levels
    logic [1:0]  dma_q;                // DMA request pulses
    logic [31:0] rdata_q;              // Read data
    logic        irq_q;                // Interrupt output

    // ==========================================================
    // Edge sources
    // ==========================================================
    logic       ext_tick;              // External clock rising edge
    logic [3:0] cap_evt;               // Capture events

    gtimer_ext_clk u_ext_clk
    (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .i_pin  (i_ext_clk),
        .o_tick (ext_tick)
    );

    // Per-channel capture synchroniser and edge select
    generate
        for (genvar g = 0; g < NUM_CH; g++)
        begin : g_cap
            gtimer_capture u_cap
            (
                .i_clk   (i_clk),
                .i_srst  (i_srst),
                .i_pin   (i_cap[g]),
                .i_edge  (gtimer_pkg::cap_edge_t'(cctrl_q[3*g +: 2])),
                .o_event (cap_evt[g])
            );
        end
    endgenerate

    // Register index decode used by the read path only
    function automatic logic [1:0] ch_of(input logic [7:0] a);
        ch_of = a[3:2];
    endfunction : ch_of

    // ==========================================================
    // Counting control
    // ==========================================================
    logic       src_tick;              // Clock source pulse
    logic       presc_wrap;            // Prescaler reached its value
    logic [3:0] hit;                   // Counter equals shadow
    logic [3:0] hit_evt;               // Hit on a counter step
    logic       clr_cap;               // Capture-triggered clear
    logic       any_stop;              // Some match stops the counter
    logic       any_reset;             // Some match resets the counter
    logic       running;               // Counting allowed

    assign running  = ctrl_q[gtimer_pkg::CTRL_RUN] & ~ctrl_q[gtimer_pkg::CTRL_RST];
    // Timer mode counts every cycle, counter mode counts pin edges
    assign src_tick = ctrl_q[gtimer_pkg::CTRL_EXTCLK] ? ext_tick : 1'b1;
    assign presc_wrap = running & src_tick & (pcount_q == prescale_q);
    assign clr_cap  = ctrl_q[gtimer_pkg::CTRL_CLRCAP_EN]
                    & cap_evt[ctrl_q[gtimer_pkg::CTRL_CLRCAP_SEL +: 2]];

    // Compare each shadow value against the live count
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            hit[i] = (count_q == shadow_q[i]);
        end
    end
    // Act on a match only once, on the prescale tick that steps the counter off it
    assign hit_evt   = hit & {4{presc_wrap}};
    assign any_stop  = |(hit_evt & {mctrl_q[11], mctrl_q[8], mctrl_q[5], mctrl_q[2]});
    assign any_reset = |(hit_evt & {mctrl_q[10], mctrl_q[7], mctrl_q[4], mctrl_q[1]});

    // Prescale counter
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            pcount_q <= gtimer_pkg::RST_ZERO;
        else if (ctrl_q[gtimer_pkg::CTRL_RST] || clr_cap)
            pcount_q <= gtimer_pkg::RST_ZERO;
        else if (i_wr && i_addr == gtimer_pkg::ADDR_PCOUNT)
            pcount_q <= i_wdata;
        else if (presc_wrap)
            pcount_q <= gtimer_pkg::RST_ZERO;
        else if (running && src_tick)
            pcount_q <= pcount_q + 32'h0000_0001;
    end

    // Main counter
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            count_q <= gtimer_pkg::RST_ZERO;
        else if (ctrl_q[gtimer_pkg::CTRL_RST] || clr_cap)
            count_q <= gtimer_pkg::RST_ZERO;
        else if (i_wr && i_addr == gtimer_pkg::ADDR_COUNT)
            count_q <= i_wdata;
        else if (any_reset)
            count_q <= gtimer_pkg::RST_ZERO;
        else if (presc_wrap)
            count_q <= count_q + 32'h0000_0001;
    end

    // Control register; a stop match clears the run bit
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            ctrl_q <= gtimer_pkg::RST_ZERO;
        else
        begin
            // Write never lost; a same-cycle stop still wins for run
            if (i_wr && i_addr == gtimer_pkg::ADDR_CTRL)
                ctrl_q <= {26'h0, i_wdata[5:0]};
            if (any_stop)
                ctrl_q[gtimer_pkg::CTRL_RUN] <= 1'b0;
        end
    end

    // ==========================================================
    // Plain configuration registers
    // ==========================================================
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            prescale_q <= gtimer_pkg::RST_ZERO;
            mctrl_q    <= 12'h000;
            cctrl_q    <= 12'h000;
            emctrl_q   <= 12'h000;
            pwm_en_q   <= 4'h0;
            dmasel_q   <= 4'h0;
            irq_mask_q <= 8'h00;
        end
        else if (i_wr)
        begin
            if (i_addr == gtimer_pkg::ADDR_PRESCALE)
                prescale_q <= i_wdata;
            else if (i_addr == gtimer_pkg::ADDR_MCTRL)
                mctrl_q <= i_wdata[11:0];
            else if (i_addr == gtimer_pkg::ADDR_CCTRL)
                cctrl_q <= i_wdata[11:0];
            else if (i_addr == gtimer_pkg::ADDR_EMCTRL)
                emctrl_q <= i_wdata[11:0];
            else if (i_addr == gtimer_pkg::ADDR_PWMCTRL)
                pwm_en_q <= {1'b0, i_wdata[2:0]};
            else if (i_addr == gtimer_pkg::ADDR_DMACTRL)
                dmasel_q <= i_wdata[3:0];
            else if (i_addr == gtimer_pkg::ADDR_IRQ_MASK)
                irq_mask_q <= i_wdata[7:0];
        end
    end

    // ==========================================================
    // Match values and shadows
    // ==========================================================
    // Software writes only the holding copy; the compare copy is
    // refreshed when the counter restarts so a PWM edge never moves
    // in the middle of a period.
    logic period_restart;              // Counter is returning to zero
    assign period_restart = any_reset | ctrl_q[gtimer_pkg::CTRL_RST] | clr_cap;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                match_q[i]  <= gtimer_pkg::RST_MATCH;
                shadow_q[i] <= gtimer_pkg::RST_MATCH;
            end
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (i_wr && i_addr == gtimer_pkg::ADDR_MATCH0 + 8'(4*i))
                    match_q[i] <= i_wdata;
                // Load shadow at restart, or anytime while stopped
                if (period_restart || !ctrl_q[gtimer_pkg::CTRL_RUN])
                    shadow_q[i] <= match_q[i];
            end
        end
    end

    // Capture registers
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            for (int i = 0; i < NUM_CH; i++)
                cap_q[i] <= gtimer_pkg::RST_ZERO;
        end
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (cap_evt[i])
                    cap_q[i] <= count_q;
            end
        end
    end

    // ==========================================================
    // Match outputs and PWM
    // ==========================================================
    // PWM channels go low at reset of period, high at their match;
    // match 3 sets the period and has no PWM output of its own.
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            match_out_q <= 4'h0;
        else
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                if (pwm_en_q[i])
                begin
                    if (period_restart)
                        match_out_q[i] <= 1'b0;
                    else if (hit_evt[i])
                        match_out_q[i] <= 1'b1;
                end
                else if (hit_evt[i])
                begin
                    case (gtimer_pkg::em_act_t'(emctrl_q[3*i +: 2]))
                        gtimer_pkg::EM_LOW:    match_out_q[i] <= 1'b0;
                        gtimer_pkg::EM_HIGH:   match_out_q[i] <= 1'b1;
                        gtimer_pkg::EM_TOGGLE: match_out_q[i] <= ~match_out_q[i];
                        default:               match_out_q[i] <= match_out_q[i];
                    endcase
                end
            end
        end
    end

    // DMA: two request lines, each picks one match channel
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            dma_q <= 2'h0;
        else
        begin
            dma_q[0] <= hit_evt[dmasel_q[1:0]];
            dma_q[1] <= hit_evt[dmasel_q[3:2]];
        end
    end

    // ==========================================================
    // Interrupt status, mask and output
    // ==========================================================
    logic [7:0] irq_set;               // New events this cycle
    always_comb
    begin
        for (int i = 0; i < NUM_CH; i++)
        begin
            irq_set[i] = hit_evt[i] & mctrl_q[3*i];
            irq_set[gtimer_pkg::IRQ_CAP_BASE + i] = cap_evt[i] & cctrl_q[3*i+2];
        end
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            irq_stat_q <= 8'h00;
        else if (i_wr && i_addr == gtimer_pkg::ADDR_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~i_wdata[7:0]) | irq_set;
        else
            irq_stat_q <= irq_stat_q | irq_set;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            irq_q <= 1'b0;
        else
            irq_q <= |(irq_stat_q & irq_mask_q);
    end

    // ==========================================================
    // Read path, data in the cycle after the strobe
    // ==========================================================
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
            rdata_q <= gtimer_pkg::RST_ZERO;
        else if (!i_rd)
            rdata_q <= gtimer_pkg::RST_ZERO;
        else if (i_addr == gtimer_pkg::ADDR_CTRL)
            rdata_q <= ctrl_q;
        else if (i_addr == gtimer_pkg::ADDR_COUNT)
            rdata_q <= count_q;
        else if (i_addr == gtimer_pkg::ADDR_PRESCALE)
            rdata_q <= prescale_q;
        else if (i_addr == gtimer_pkg::ADDR_PCOUNT)
            rdata_q <= pcount_q;
        else if (i_addr == gtimer_pkg::ADDR_MCTRL)
            rdata_q <= {20'h0, mctrl_q};
        else if (i_addr == gtimer_pkg::ADDR_CCTRL)
            rdata_q <= {20'h0, cctrl_q};
        else if (i_addr == gtimer_pkg::ADDR_EMCTRL)
            rdata_q <= {16'h0, match_out_q, emctrl_q};
        else if (i_addr == gtimer_pkg::ADDR_PWMCTRL)
            rdata_q <= {28'h0, pwm_en_q};
        else if (i_addr == gtimer_pkg::ADDR_DMACTRL)
            rdata_q <= {28'h0, dmasel_q};
        else if (i_addr == gtimer_pkg::ADDR_IRQ_STAT)
            rdata_q <= {24'h0, irq_stat_q};
        else if (i_addr == gtimer_pkg::ADDR_IRQ_MASK)
            rdata_q <= {24'h0, irq_mask_q};
        else if (i_addr[7:4] == gtimer_pkg::ADDR_MATCH0[7:4] && i_addr[1:0] == 2'h0)
            rdata_q <= match_q[ch_of(i_addr)];
        else if (i_addr[7:4] == gtimer_pkg::ADDR_CAP0[7:4] && i_addr[1:0] == 2'h0)
            rdata_q <= cap_q[ch_of(i_addr)];
        else
            rdata_q <= gtimer_pkg::RST_ZERO;   // Unmapped reads as zero
    end

    assign o_rdata   = rdata_q;
    assign o_match   = match_out_q;
    assign o_dma_req = dma_q;
    assign o_irq     = irq_q;

endmodule : gtimer_top

// ---- sim/gtimer_chk.sv ----
`timescale 1ns/1ps
// ==========================================
// Port checks: bus answers, irq gating, pins
module gtimer_chk
(
    // Clock, reset, register port
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // Pins and requests
    input wire logic        i_ext_clk,
    input wire logic [3:0]  i_cap,
    input wire logic [3:0]  o_match,
    input wire logic [1:0]  o_dma_req,
    input wire logic        o_irq
);
    logic [31:0] ctrl_q; // Control as software wrote it
    logic [31:0] mask_q; // Mask as software wrote it
    // Software view only; stop on match is not seen here
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            ctrl_q <= 32'h0;
            mask_q <= 32'h0;
        end
        else if (i_wr)
        begin
            if (i_addr == gtimer_pkg::ADDR_CTRL)
                ctrl_q <= i_wdata;
            if (i_addr == gtimer_pkg::ADDR_IRQ_MASK)
                mask_q <= i_wdata;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    a_reset_outputs: assert property (disable iff (1'b0) i_srst |=> o_irq == 1'b0
        && o_match == 4'h0 && o_dma_req == 2'h0 && o_rdata == 32'h0) else $error("reset out");
    a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("rdata idle");
    a_unmapped_zero: assert property (i_rd && i_addr == 8'hfc |=> o_rdata == 32'h0)
        else $error("unmapped read");
    a_ctrl_readback: assert property (i_rd && i_addr == gtimer_pkg::ADDR_CTRL
        |=> o_rdata[5:2] == $past(ctrl_q[5:2])) else $error("ctrl read");
    a_mask_readback: assert property (i_rd && i_addr == gtimer_pkg::ADDR_IRQ_MASK
        |=> o_rdata[7:0] == $past(mask_q[7:0])) else $error("mask read");
    a_irq_masked: assert property (mask_q == 32'h0 && $past(mask_q) == 32'h0 |-> !o_irq)
        else $error("masked irq");
    a_dma_needs_run: assert property (o_dma_req != 2'h0
        |-> $past(ctrl_q[0]) || $past(ctrl_q[0], 2)) else $error("dma while stopped");
    a_match_stable: assert property (!ctrl_q[0] && !$past(ctrl_q[0]) &&
        !$past(ctrl_q[0], 2) && !$past(i_wr) |-> $stable(o_match)) else $error("match moved");
endmodule : gtimer_chk

bind gtimer_top gtimer_chk u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(i_ext_clk),
    .i_cap(i_cap), .o_match(o_match), .o_dma_req(o_dma_req), .o_irq(o_irq));

// ---- sim/gtimer_pins.sv ----
`timescale 1ns/1ps
// ==========================================
// Far side: capture pins and external count clock
module gtimer_pins
(
    // Clock, reset, requests from the bench
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    input  wire logic [3:0] i_cap_req,
    input  wire logic [7:0] i_ext_req,
    // Pins toward the timer
    output logic      [3:0] o_cap,
    output logic            o_ext_clk
);
    logic [3:0] hold_q [4]; // High time left per capture pin
    logic [9:0] ph_q;       // Ext clock phases left, idles low
    // Eight-cycle pulse, well past the two-stage synchroniser
    always_ff @(posedge i_clk)
    begin
        for (int c = 0; c < 4; c++)
            hold_q[c] <= i_srst ? 4'h0 : i_cap_req[c] ? 4'h8 : hold_q[c] - 4'(hold_q[c] != 0);
        ph_q <= i_srst ? 10'h0 : (i_ext_req != 0) ? {i_ext_req, 2'h0} : ph_q - 10'(ph_q != 0);
    end
    // Pin levels
    always_comb
    begin
        for (int c = 0; c < 4; c++)
            o_cap[c] = hold_q[c] != 4'h0;
        o_ext_clk = ph_q[1];
    end
endmodule : gtimer_pins

// ---- sim/gtimer_tb_top.sv ----
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the timer
module gtimer_tb_top;
    logic        i_clk = 1'b0;       // System clock
    logic        i_srst, i_wr, i_rd; // Reset, strobes
    logic [7:0]  i_addr, ext_req;    // Address, ext edges wanted
    logic [31:0] i_wdata, o_rdata, v; // Bus data, read result
    logic [3:0]  cap, mt, cap_req;   // Pins, pulse requests
    logic [1:0]  dma;                // DMA requests
    logic        ext, irq, mv;       // Ext clock, irq, saved level
    int          errors, n_compared, seed, p, n, t0;
    always #10 i_clk = ~i_clk;
    gtimer_top DUT (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_clk(ext), .i_cap(cap),
        .o_match(mt), .o_dma_req(dma), .o_irq(irq));
    gtimer_pins u_pins (.i_clk(i_clk), .i_srst(i_srst), .i_cap_req(cap_req),
        .i_ext_req(ext_req), .o_cap(cap), .o_ext_clk(ext));
    // Bus tasks leave one idle cycle so no strobe is set twice at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
        @(posedge i_clk);
        i_wr <= 1'b0;
        @(posedge i_clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        {i_addr, i_rd} <= {a, 1'b1};
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
        @(posedge i_clk);
    endtask : rd
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic summarize;
        $display("errors=%0d n_compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    // Bounded wait for a DMA pulse, returns cycles waited
    task automatic wait_dma(output int t);
        t = 0;
        do
        begin
            @(posedge i_clk);
            #1 t++;
        end while (dma[0] !== 1'b1 && t < 200);
    endtask : wait_dma
    // Main count or prescale remainder after k ticks
    function automatic logic [31:0] steps(input int k, input int q, input bit r);
        return r ? 32'(k % (q + 1)) : 32'(k / (q + 1));
    endfunction : steps
    // Watchdog, far beyond the expected run
    initial
    begin
        #200_000;
        errors++;
        summarize();
    end
    initial
    begin
        {i_srst, i_wr, i_rd, i_addr, i_wdata, cap_req, ext_req} = {1'b1, 54'h0};
        errors = 0;
        n_compared = 0;
        seed = 32'hbbb7;
        repeat (3) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        rd(gtimer_pkg::ADDR_MATCH0, v);
        check(v, gtimer_pkg::RST_MATCH);
        rd(8'hfc, v);
        check(v, 32'h0);
        // Random prescale, system clock then external clock
        for (int m = 0; m < 2; m++)
        begin
            p = $unsigned($random(seed)) % 4;
            n = $unsigned($random(seed)) % 40;
            wr(gtimer_pkg::ADDR_PRESCALE, p);
            wr(gtimer_pkg::ADDR_COUNT, 32'h0);
            wr(gtimer_pkg::ADDR_PCOUNT, 32'h0);
            wr(gtimer_pkg::ADDR_CTRL, m ? 32'h5 : 32'h1);
            ext_req <= 8'(n * m);
            @(posedge i_clk);
            ext_req <= 8'h0;
            repeat (m ? 4 * n + 8 : n) @(posedge i_clk);
            wr(gtimer_pkg::ADDR_CTRL, 32'h0);
            rd(gtimer_pkg::ADDR_COUNT, v);
            check(v, steps(m ? n : n + 3, p, 1'b0));
            rd(gtimer_pkg::ADDR_PCOUNT, v);
            check(v, steps(m ? n : n + 3, p, 1'b1));
        end
        rd(gtimer_pkg::ADDR_CTRL, v);
        check(v, 32'h0);
        // Capture: channel c uses edge code c, zero means off
        wr(gtimer_pkg::ADDR_IRQ_MASK, 32'hf0);
        rd(gtimer_pkg::ADDR_IRQ_MASK, v);
        check(v, 32'hf0);
        for (int c = 0; c < 4; c++)
        begin
            t0 = $random(seed);
            wr(gtimer_pkg::ADDR_COUNT, t0);
            wr(gtimer_pkg::ADDR_CCTRL, 32'(4 + c) << (3 * c));
            cap_req <= 4'h1 << c;
            @(posedge i_clk);
            cap_req <= 4'h0;
            repeat (16) @(posedge i_clk);
            rd(gtimer_pkg::ADDR_CAP0 + 8'(4 * c), v);
            check(v, c ? t0 : 32'h0);
            rd(gtimer_pkg::ADDR_IRQ_STAT, v);
            check(v & 32'hf0, c ? 32'h10 << c : 32'h0);
            check({31'h0, irq}, 32'(c != 0));
            wr(gtimer_pkg::ADDR_IRQ_STAT, 32'hf0);
            repeat (2) @(posedge i_clk);
            check({31'h0, irq}, 32'h0);
        end
        // Match 0 resets count, toggles its pin, raises irq and DMA
        t0 = 4 + $unsigned($random(seed)) % 8;
        wr(gtimer_pkg::ADDR_MATCH0, t0);
        wr(gtimer_pkg::ADDR_MCTRL, 32'h3);
        wr(gtimer_pkg::ADDR_EMCTRL, 32'h3);
        wr(gtimer_pkg::ADDR_IRQ_MASK, 32'h1);
        wr(gtimer_pkg::ADDR_PRESCALE, 32'h0);
        wr(gtimer_pkg::ADDR_PCOUNT, 32'h0);
        wr(gtimer_pkg::ADDR_COUNT, 32'h0);
        wr(gtimer_pkg::ADDR_CTRL, 32'h1);
        wait_dma(n);
        check(n, t0);
        mv = mt[0];
        wait_dma(n);
        check(n, t0 + 1);
        check({30'h0, dma}, 32'h3);
        check({31'h0, mt[0]}, {31'h0, ~mv});
        check({31'h0, irq}, 32'h1);
        // Stop on match clears the run bit
        wr(gtimer_pkg::ADDR_MCTRL, 32'h4);
        repeat (16) @(posedge i_clk);
        rd(gtimer_pkg::ADDR_CTRL, v);
        check(v, 32'h0);
        summarize();
    end
endmodule : gtimer_tb_top
